// ### hw/core_control_pkg.sv
// Constants shared by the core control register block
package core_control_pkg;
  localparam int          REG_W          = 16;
  localparam int          ADDR_W         = 4;
  localparam int          LEVEL_W        = 4;
  localparam int          DEPTH_W        = 3;
  // Byte addresses of the registers
  localparam logic [3:0]  OFS_CORE       = 4'h0;
  localparam logic [3:0]  OFS_STATUS     = 4'h4;
  localparam logic [3:0]  OFS_NEST       = 4'h8;
  localparam logic [3:0]  OFS_VIEW       = 4'hc;
  // Field positions in core_control
  localparam int          BIT_FRAC_INT   = 0;
  localparam int          BIT_ROUND      = 1;
  localparam int          BIT_PSV        = 2;
  localparam int          BIT_MSB        = 3;
  localparam int          BIT_ACC_SAT    = 4;
  localparam int          BIT_SAT_DW     = 5;
  localparam int          BIT_SAT_B      = 6;
  localparam int          BIT_SAT_A      = 7;
  localparam int          BIT_DEPTH_LO   = 8;
  localparam int          BIT_TERMINATE  = 11;
  localparam int          BIT_UNSIGNED   = 12;
  // Field positions in the status image, nesting control and view register
  localparam int          BIT_LOW_LO     = 5;
  localparam int          BIT_NEST_DIS   = 0;
  localparam int          BIT_BLOCKED    = 4;
  // Values after reset, write masks and low priority bit codes
  localparam logic [15:0] CORE_RESET     = 16'h0020;
  localparam logic [15:0] CORE_WRITABLE  = 16'h10f7;
  localparam logic [2:0]  LOW_RESET      = 3'h0;
  localparam logic [2:0]  LOW_USER_OFF   = 3'h7;
  localparam logic [2:0]  LOW_ZERO       = 3'h0;
  localparam logic [3:0]  LEVEL_RESET    = 4'h0;
  // AXI4-Lite responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage : core_control_pkg

// ### hw/reg_access_if.sv
// Register access strobes between the bus port and the register bank
`timescale 1ns/100ps
`default_nettype none
interface reg_access_if;
  import core_control_pkg::*;
  logic              wr_en;
  logic              rd_en;
  logic [ADDR_W-1:0] addr;
  logic [REG_W-1:0]  wdata;
  logic [1:0]        wstrb;
  logic [REG_W-1:0]  rdata;
  logic              err;
  modport bus  (output wr_en, rd_en, addr, wdata, wstrb, input rdata, err);
  modport regs (input wr_en, rd_en, addr, wdata, wstrb, output rdata, err);
endinterface : reg_access_if
`default_nettype wire

// ### hw/axil_reg_port.sv
// AXI4-Lite slave front end that turns bus transfers into register strobes
`timescale 1ns/100ps
`default_nettype none
module axil_reg_port
  import core_control_pkg::*;
(
  input  wire logic              sys_clk,     // Core clock
  input  wire logic              reset_n,     // Async reset
  input  wire logic [ADDR_W-1:0] awaddr,      // Write address
  input  wire logic              awvalid,     // Write address valid
  output logic                   awready,     // Write address ready
  input  wire logic [31:0]       wdata,       // Write data
  input  wire logic [3:0]        wstrb,       // Write strobes
  input  wire logic              wvalid,      // Write data valid
  output logic                   wready,      // Write data ready
  output logic [1:0]             bresp,       // Write response
  output logic                   bvalid,      // Write response valid
  input  wire logic              bready,      // Write response ready
  input  wire logic [ADDR_W-1:0] araddr,      // Read address
  input  wire logic              arvalid,     // Read address valid
  output logic                   arready,     // Read address ready
  output logic [31:0]            rdata,       // Read data
  output logic [1:0]             rresp,       // Read response
  output logic                   rvalid,      // Read data valid
  input  wire logic              rready,      // Read data ready
  reg_access_if.bus              acc          // Register strobes
);
  logic              aw_held, w_held, ar_held;
  logic              next_aw_held, next_w_held, next_ar_held;
  logic [ADDR_W-1:0] aw_addr_q, ar_addr_q, next_aw_addr, next_ar_addr;
  logic [REG_W-1:0]  wdata_q, next_wdata;
  logic [1:0]        wstrb_q, next_wstrb;
  logic              next_awready, next_wready, next_arready;
  logic              next_bvalid, next_rvalid;
  logic [1:0]        next_bresp, next_rresp;
  logic [31:0]       next_rdata;
  logic              do_write, do_read;

  // Write wins a shared cycle; the read simply waits one cycle
  assign do_write  = aw_held && w_held && !bvalid;
  assign do_read   = ar_held && !rvalid && !do_write;
  assign acc.wr_en = do_write;
  assign acc.rd_en = do_read;
  assign acc.addr  = do_write ? aw_addr_q : ar_addr_q;
  assign acc.wdata = wdata_q;
  assign acc.wstrb = wstrb_q;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_ar_held = ar_held;
    next_aw_addr = aw_addr_q;
    next_ar_addr = ar_addr_q;
    next_wdata   = wdata_q;
    next_wstrb   = wstrb_q;
    next_awready = awready;
    next_wready  = wready;
    next_arready = arready;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rresp   = rresp;
    next_rdata   = rdata;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
      next_awready = 1'b0;
    end
    if (wvalid && wready) begin
      next_w_held = 1'b1;
      next_wdata  = wdata[REG_W-1:0];
      next_wstrb  = wstrb[1:0];
      next_wready = 1'b0;
    end
    if (arvalid && arready) begin
      next_ar_held = 1'b1;
      next_ar_addr = araddr;
      next_arready = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = acc.err ? RESP_SLVERR : RESP_OKAY;
    end else if (bvalid && bready) begin
      next_bvalid  = 1'b0;
      next_awready = 1'b1;
      next_wready  = 1'b1;
    end
    if (do_read) begin
      next_ar_held = 1'b0;
      next_rvalid  = 1'b1;
      next_rdata   = {16'h0000, acc.rdata};
      next_rresp   = acc.err ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid && rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      ar_held   <= 1'b0;
      aw_addr_q <= '0;
      ar_addr_q <= '0;
      wdata_q   <= '0;
      wstrb_q   <= 2'h0;
      awready   <= 1'b1;
      wready    <= 1'b1;
      arready   <= 1'b1;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      rvalid    <= 1'b0;
      rresp     <= RESP_OKAY;
      rdata     <= 32'h0000_0000;
    end else begin
      aw_held   <= next_aw_held;
      w_held    <= next_w_held;
      ar_held   <= next_ar_held;
      aw_addr_q <= next_aw_addr;
      ar_addr_q <= next_ar_addr;
      wdata_q   <= next_wdata;
      wstrb_q   <= next_wstrb;
      awready   <= next_awready;
      wready    <= next_wready;
      arready   <= next_arready;
      bvalid    <= next_bvalid;
      bresp     <= next_bresp;
      rvalid    <= next_rvalid;
      rresp     <= next_rresp;
      rdata     <= next_rdata;
    end
  end
endmodule : axil_reg_port
`default_nettype wire

// ### hw/core_control_register.sv
// Core control register bank with interrupt priority level logic
//
// How it works
// - Priority level is the MSB bit above the three low status bits.
// - While the MSB is set, all user interrupts are blocked.
// - With MSB set, the level is the upper alternative, eight plus low bits.
// - Nesting disable set makes the three low priority bits read-only.
// - The early loop-termination bit always reads back as zero.
// - MSB clear: low bits 111 mean level seven, user off; 000 mean zero.
`timescale 1ns/100ps
`default_nettype none
module core_control_register
  import core_control_pkg::*;
#(
  parameter int AXI_ADDR_W = ADDR_W
)(
  input  wire logic                  sys_clk,                 // 40 MHz core clock
  input  wire logic                  reset_n,                 // Async reset, active low
  input  wire logic [AXI_ADDR_W-1:0] awaddr,                  // Write address
  input  wire logic                  awvalid,                 // Write address valid
  output logic                       awready,                 // Write address ready
  input  wire logic [31:0]           wdata,                   // Write data
  input  wire logic [3:0]            wstrb,                   // Write strobes
  input  wire logic                  wvalid,                  // Write data valid
  output logic                       wready,                  // Write data ready
  output logic [1:0]                 bresp,                   // Write response
  output logic                       bvalid,                  // Write response valid
  input  wire logic                  bready,                  // Write response ready
  input  wire logic [AXI_ADDR_W-1:0] araddr,                  // Read address
  input  wire logic                  arvalid,                 // Read address valid
  output logic                       arready,                 // Read address ready
  output logic [31:0]                rdata,                   // Read data
  output logic [1:0]                 rresp,                   // Read response
  output logic                       rvalid,                  // Read data valid
  input  wire logic                  rready,                  // Read data ready
  input  wire logic [DEPTH_W-1:0]    loop_nest_depth,         // Active hardware loop count
  input  wire logic                  loop_iteration_end,      // Pulse at loop iteration end
  input  wire logic                  level_load,              // Core loads priority level
  input  wire logic [LEVEL_W-1:0]    level_value,             // Level loaded by the core
  output logic                       multiply_unsigned,       // DSP multiply unsigned
  output logic                       multiply_integer,        // DSP multiply integer mode
  output logic                       round_conventional,      // Biased rounding
  output logic                       psv_enable,              // Program space visible
  output logic                       acc_super_sat,           // 9.31 saturation
  output logic                       sat_data_write,          // Data write saturation
  output logic                       sat_acc_b,               // Accumulator B saturation
  output logic                       sat_acc_a,               // Accumulator A saturation
  output logic                       loop_early_terminate,    // Pending loop end request
  output logic [LEVEL_W-1:0]         cpu_priority_level,      // Effective priority level
  output logic                       user_interrupts_blocked  // User interrupts disabled
);
  generate
    if (AXI_ADDR_W != ADDR_W) begin : g_bad_addr
      $error("AXI_ADDR_W must equal the register address width");
    end
  endgenerate

  reg_access_if acc ();

  axil_reg_port u_port (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .acc     (acc)
  );

  function automatic logic hits(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hits = (a == ofs);
  endfunction : hits

  logic [REG_W-1:0]   core;
  logic [REG_W-1:0]   next_core;
  logic [2:0]         low_level;
  logic [2:0]         next_low_level;
  logic               nest_disable;
  logic               next_nest_disable;
  logic               next_terminate;
  logic [LEVEL_W-1:0] next_level;
  logic               next_blocked;
  logic [REG_W-1:0]   byte_mask;
  logic               wr_core, wr_status, wr_nest, terminate_set;

  assign byte_mask     = {{8{acc.wstrb[1]}}, {8{acc.wstrb[0]}}};
  assign wr_core       = acc.wr_en && hits(acc.addr, OFS_CORE);
  assign wr_status     = acc.wr_en && hits(acc.addr, OFS_STATUS) && acc.wstrb[0];
  assign wr_nest       = acc.wr_en && hits(acc.addr, OFS_NEST) && acc.wstrb[0];
  assign terminate_set = wr_core && acc.wstrb[1] && acc.wdata[BIT_TERMINATE];

  always_comb begin
    next_core         = core;
    next_low_level    = low_level;
    next_nest_disable = nest_disable;
    next_terminate    = loop_early_terminate;
    if (wr_core) begin
      next_core = (core & ~(byte_mask & CORE_WRITABLE)) | (acc.wdata & byte_mask & CORE_WRITABLE);
      // MSB is clear-only from software
      if (acc.wstrb[0] && !acc.wdata[BIT_MSB]) begin
        next_core[BIT_MSB] = 1'b0;
      end
    end
    if (wr_nest) begin
      next_nest_disable = acc.wdata[BIT_NEST_DIS];
    end
    if (wr_status && !nest_disable) begin
      next_low_level = acc.wdata[BIT_LOW_LO +: 3];
    end
    // Core load wins over a software write in the same cycle
    if (level_load) begin
      next_core[BIT_MSB] = level_value[LEVEL_W-1];
      next_low_level     = level_value[2:0];
    end
    // Request holds until the loop engine reaches an iteration end; a new set wins
    if (loop_iteration_end) begin
      next_terminate = 1'b0;
    end
    if (terminate_set) begin
      next_terminate = 1'b1;
    end
    next_level   = {next_core[BIT_MSB], next_low_level};
    next_blocked = next_core[BIT_MSB] || (next_low_level == LOW_USER_OFF);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      core                    <= CORE_RESET;
      low_level               <= LOW_RESET;
      nest_disable            <= 1'b0;
      loop_early_terminate    <= 1'b0;
      cpu_priority_level      <= LEVEL_RESET;
      user_interrupts_blocked <= 1'b0;
    end else begin
      core                    <= next_core;
      low_level               <= next_low_level;
      nest_disable            <= next_nest_disable;
      loop_early_terminate    <= next_terminate;
      cpu_priority_level      <= next_level;
      user_interrupts_blocked <= next_blocked;
    end
  end

  assign multiply_unsigned  = core[BIT_UNSIGNED];
  assign multiply_integer   = core[BIT_FRAC_INT];
  assign round_conventional = core[BIT_ROUND];
  assign psv_enable         = core[BIT_PSV];
  assign acc_super_sat      = core[BIT_ACC_SAT];
  assign sat_data_write     = core[BIT_SAT_DW];
  assign sat_acc_b          = core[BIT_SAT_B];
  assign sat_acc_a          = core[BIT_SAT_A];

  // Read decode; writes to the view register are accepted and ignored
  always_comb begin
    acc.rdata = 16'h0000;
    acc.err   = 1'b0;
    if (hits(acc.addr, OFS_CORE)) begin
      acc.rdata                           = core & CORE_WRITABLE;
      acc.rdata[BIT_MSB]                  = core[BIT_MSB];
      acc.rdata[BIT_DEPTH_LO +: DEPTH_W]  = loop_nest_depth;
      acc.rdata[BIT_TERMINATE]            = 1'b0;
    end else if (hits(acc.addr, OFS_STATUS)) begin
      acc.rdata[BIT_LOW_LO +: 3] = low_level;
    end else if (hits(acc.addr, OFS_NEST)) begin
      acc.rdata[BIT_NEST_DIS] = nest_disable;
    end else if (hits(acc.addr, OFS_VIEW)) begin
      acc.rdata[LEVEL_W-1:0] = cpu_priority_level;
      acc.rdata[BIT_BLOCKED] = user_interrupts_blocked;
    end else begin
      acc.err = 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_term_written;
    terminate_set;
  endsequence
  sequence s_term_pending;
    loop_early_terminate && !loop_iteration_end;
  endsequence

  a_level_concat: assert property (
    cpu_priority_level == {core[BIT_MSB], low_level})
    else $error("priority level is not msb over low bits");
  a_msb_blocks_user: assert property (
    core[BIT_MSB] |-> user_interrupts_blocked)
    else $error("user interrupts open while msb set");
  a_msb_upper_level: assert property (
    $rose(core[BIT_MSB]) |-> cpu_priority_level == 4'h8 + {1'b0, low_level})
    else $error("msb set but level not in upper half");
  a_nest_locks_low: assert property (
    nest_disable && wr_status && !level_load |=> $stable(low_level))
    else $error("low priority bits changed while nesting disabled");
  a_terminate_reads_zero: assert property (
    acc.rd_en && hits(acc.addr, OFS_CORE) |=> rvalid && rdata[BIT_TERMINATE] == 1'b0)
    else $error("terminate bit read back as one");
  // A pending request must survive every cycle without an iteration end
  a_terminate_request: assert property (
    (s_term_written or s_term_pending) |=> loop_early_terminate)
    else $error("terminate write did not raise or hold request");
  a_terminate_release: assert property (
    loop_iteration_end && !terminate_set |=> !loop_early_terminate)
    else $error("loop end request not dropped at iteration end");
  a_terminate_zero_noop: assert property (
    !loop_early_terminate && !terminate_set |=> !loop_early_terminate)
    else $error("loop end request without a write of one");
  a_seven_user_off: assert property (
    !core[BIT_MSB] && low_level == LOW_USER_OFF |-> user_interrupts_blocked
      && cpu_priority_level == 4'h7)
    else $error("level seven does not block user interrupts");
  a_zero_level_open: assert property (
    !core[BIT_MSB] && low_level == LOW_ZERO |-> !user_interrupts_blocked
      && cpu_priority_level == 4'h0)
    else $error("level zero wrong");
endmodule : core_control_register
`default_nettype wire

// ### bench/core_control_register_test.sv
// Self-checking bench for the core control register block
`timescale 1ns/100ps
`default_nettype none
module core_control_register_test;
  import core_control_pkg::*;
  logic [3:0]  awaddr, araddr, wstrb, level_value, cpu_priority_level, lvl_m;
  logic [31:0] wdata, rdata, rs, r;
  logic [1:0]  bresp, rresp;
  logic [2:0]  loop_nest_depth;
  logic        sys_clk, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, loop_iteration_end, level_load;
  logic        multiply_unsigned, multiply_integer, round_conventional, psv_enable;
  logic        acc_super_sat, sat_data_write, sat_acc_b, sat_acc_a, loop_early_terminate;
  logic        user_interrupts_blocked, term_m;
  logic [33:0] rd_q[$];
  logic [1:0]  wr_q[$];
  logic [15:0] core_m;
  logic [3:0]  lv[6] = '{4'h0, 4'h7, 4'hf, 4'h8, 4'h3, 4'hb};
  int          num_errors, check_count, i;

  core_control_register #(.AXI_ADDR_W(4)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .loop_nest_depth(loop_nest_depth), .loop_iteration_end(loop_iteration_end),
    .level_load(level_load), .level_value(level_value),
    .multiply_unsigned(multiply_unsigned), .multiply_integer(multiply_integer),
    .round_conventional(round_conventional), .psv_enable(psv_enable),
    .acc_super_sat(acc_super_sat), .sat_data_write(sat_data_write), .sat_acc_b(sat_acc_b),
    .sat_acc_a(sat_acc_a), .loop_early_terminate(loop_early_terminate),
    .cpu_priority_level(cpu_priority_level), .user_interrupts_blocked(user_interrupts_blocked)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs

  function automatic logic [31:0] core_exp();
    return {16'h0, 3'h0, core_m[12], 1'b0, loop_nest_depth, core_m[7:4], lvl_m[3], core_m[2:0]};
  endfunction : core_exp

  function automatic logic [31:0] view_exp();
    return {27'h0, lvl_m[3] | (lvl_m[2:0] == 3'h7), lvl_m};
  endfunction : view_exp

  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic outs();
    chk({multiply_unsigned, sat_acc_a, sat_acc_b, sat_data_write, acc_super_sat, psv_enable,
         round_conventional, multiply_integer, loop_early_terminate, user_interrupts_blocked,
         cpu_priority_level},
        {core_m[12], core_m[7:4], core_m[2:0], term_m, lvl_m[3] | (lvl_m[2:0] == 3'h7), lvl_m},
        "core outputs");
  endtask : outs

  // Bounded wait on the response; a hang ends the run as a failure
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] st,
                    input logic [1:0] resp);
    int          n;
    logic [31:0] x;
    x = xs();
    wr_q.push_back(resp);
    @(posedge sys_clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {x[15:0], d};
    wstrb   <= {x[17:16], st};
    wvalid  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) begin
      num_errors++;
      $display("mismatch at %0t: write response timed out", $time);
      give_verdict();
    end
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] resp);
    int n;
    rd_q.push_back({resp, d});
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) begin
      num_errors++;
      $display("mismatch at %0t: read response timed out", $time);
      give_verdict();
    end
  endtask : rd

  // Mirrors the writable bits; software may only clear the level MSB
  task automatic wcore(input logic [15:0] d, input logic [1:0] st);
    wr(OFS_CORE, d, st, RESP_OKAY);
    if (st[0]) begin
      core_m[7:0] = d[7:0] & CORE_WRITABLE[7:0];
      lvl_m[3]    = lvl_m[3] & d[3];
    end
    if (st[1]) begin
      core_m[12] = d[12];
      term_m     = term_m | d[11];
    end
    #1;
    outs();
  endtask : wcore

  // Response watcher: oldest note is compared with each answer
  always @(posedge sys_clk) begin
    if (reset_n && rvalid && rready) begin
      if (rd_q.size() == 0) begin
        num_errors++;
        $display("mismatch at %0t: unexpected read answer", $time);
      end else begin
        chk({rresp, rdata}, rd_q.pop_front(), "read answer");
      end
    end
    if (reset_n && bvalid && bready) begin
      if (wr_q.size() == 0) begin
        num_errors++;
        $display("mismatch at %0t: unexpected write answer", $time);
      end else begin
        chk({32'h0, bresp}, {32'h0, wr_q.pop_front()}, "write answer");
      end
    end
  end

  initial begin
    rs = 32'h0000_0040;
    core_m = CORE_RESET;
    lvl_m = LEVEL_RESET;
    term_m = 1'b0;
    num_errors = 0;
    check_count = 0;
    reset_n = 1'b0;
    {awaddr, araddr, wstrb, level_value, wdata, loop_nest_depth} = '0;
    {awvalid, wvalid, arvalid, loop_iteration_end, level_load} = '0;
    bready = 1'b1;
    rready = 1'b1;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(OFS_CORE, CORE_RESET, RESP_OKAY);
    rd(OFS_VIEW, 32'h0, RESP_OKAY);
    outs();
    for (i = 0; i < 8; i++) begin
      r = xs();
      @(posedge sys_clk);
      loop_nest_depth <= r[26:24];
      wcore(r[15:0], r[17:16]);
      rd(OFS_CORE, core_exp(), RESP_OKAY);
    end
    wcore(16'h0800, 2'b10);
    rd(OFS_CORE, core_exp(), RESP_OKAY);
    wcore(16'h0000, 2'b10);
    @(posedge sys_clk);
    loop_iteration_end <= 1'b1;
    @(posedge sys_clk);
    loop_iteration_end <= 1'b0;
    term_m = 1'b0;
    #1;
    outs();
    for (i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      level_load  <= 1'b1;
      level_value <= lv[i];
      @(posedge sys_clk);
      r = xs();
      level_load  <= 1'b0;
      level_value <= r[3:0];
      lvl_m = lv[i];
      #1;
      outs();
      rd(OFS_VIEW, view_exp(), RESP_OKAY);
      rd(OFS_STATUS, {24'h0, lvl_m[2:0], 5'h0}, RESP_OKAY);
      rd(OFS_CORE, core_exp(), RESP_OKAY);
    end
    wcore(16'h00ff, 2'b01);
    rd(OFS_VIEW, view_exp(), RESP_OKAY);
    wcore(16'h0020, 2'b01);
    rd(OFS_VIEW, view_exp(), RESP_OKAY);
    wr(OFS_NEST, 16'h0001, 2'b01, RESP_OKAY);
    wr(OFS_STATUS, 16'h00e0, 2'b01, RESP_OKAY);
    rd(OFS_STATUS, {24'h0, lvl_m[2:0], 5'h0}, RESP_OKAY);
    rd(OFS_NEST, 32'h1, RESP_OKAY);
    wr(OFS_NEST, 16'h0000, 2'b01, RESP_OKAY);
    wr(OFS_STATUS, 16'h00e0, 2'b01, RESP_OKAY);
    lvl_m[2:0] = 3'h7;
    #1;
    outs();
    rd(OFS_VIEW, view_exp(), RESP_OKAY);
    wr(4'h2, 16'hffff, 2'b11, RESP_SLVERR);
    rd(4'h2, 32'h0, RESP_SLVERR);
    wr(OFS_VIEW, 16'h0000, 2'b11, RESP_OKAY);
    rd(OFS_VIEW, view_exp(), RESP_OKAY);
    rd(OFS_CORE, core_exp(), RESP_OKAY);
    repeat (4) @(posedge sys_clk);
    if (rd_q.size() != 0 || wr_q.size() != 0) begin
      num_errors++;
      $display("mismatch at %0t: answers missing", $time);
    end
    give_verdict();
  end
endmodule : core_control_register_test
`default_nettype wire
